// File: pkg/sts_pkg.sv
package sts_pkg;

  // ----------------------------------------------------------------
  // clocking and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int PIX_HZ = 100_000;
  localparam int TICK_CYC = CLK_HZ / PIX_HZ;
  localparam int TICK_W = 9;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [TICK_W-1:0] TICK_RST = 9'h000;

  // ----------------------------------------------------------------
  // timestamp counters
  // ----------------------------------------------------------------
  localparam int TS_W = 32;
  localparam logic [TS_W-1:0] TS_RST = 32'h0000_0000;
  localparam logic [TS_W-1:0] TS_MAX = 32'hFFFF_FFFF;
  localparam int FRM_W = 16;
  localparam logic [FRM_W-1:0] FRAME_TICKS = 16'h0140;

  // ----------------------------------------------------------------
  // record header counter widths
  // ----------------------------------------------------------------
  localparam int REC_W = 18;
  localparam int EVC_W = 17;
  localparam int PIX_W = 24;
  localparam int DSC_W = 17;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // event entry fields
  // ----------------------------------------------------------------
  localparam int CCD_W = 4;
  localparam int ROW_W = 10;
  localparam int COL_W = 10;
  localparam int PH_W = 12;
  localparam int OVC_W = 8;
  localparam int BIAS_W = 12;
  localparam int GRD_W = 8;

  // ----------------------------------------------------------------
  // word counts and stream geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int FIFO_D = 8;
  localparam int IDX_W = 3;
  localparam int BIT_W = 6;
  localparam logic [BIT_W-1:0] WORD_BITS = 6'h20;
  localparam logic [IDX_W-1:0] FNT_LAST = 3'h2;
  localparam logic [IDX_W-1:0] GRD_LAST = 3'h1;
  localparam logic [IDX_W-1:0] HDR_LAST_G = 3'h7;
  localparam logic [IDX_W-1:0] HDR_LAST_N = 3'h6;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_EVT, SEQ_HDR} sts_seq_e;

endpackage : sts_pkg

// File: src/sts_fifo.sv
`timescale 1ns/1ps
module sts_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic mclk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [W-1:0] in_data, // write word
  output logic out_valid, // read word present
  input wire logic out_ready, // consumer takes word
  output logic [W-1:0] out_data // read word, registered
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } sts_fifo_s;

  sts_fifo_s q, n;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != (AW+1)'(D));
  assign out_valid = q.ov;
  assign out_data = q.od;

  always_comb begin
    n = q;
    push = in_valid && in_ready;
    // output register refills whenever it is empty or being taken
    pop = (q.cnt != '0) && (!q.ov || out_ready);
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp = AW'(q.wp + 1'b1);
    end
    if (pop) begin
      n.od = q.mem[q.rp];
      n.rp = AW'(q.rp + 1'b1);
      n.ov = 1'b1;
    end else if (out_ready) begin
      n.ov = 1'b0;
    end
    n.cnt = (AW+1)'(q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule : sts_fifo

// File: src/sts_timestamp.sv
// Function
// (RULE_01) frame pulse puts timestamp first in stream
// (RULE_02) timestamp counts pixel ticks since reset/wrap
// (RULE_03) run start samples the same counter
// (RULE_04) one pixel period resolution, 100 kHz
// (RULE_05) records indexed by run-relative record counts
// (RULE_06) block aligns timing to frame sync
// (RULE_07) master counter cleared only at power-up
// (RULE_08) free-running 32-bit master counter
// (RULE_09) rollover broadcasts slave reset pulse
// (RULE_10) slave side issues beginning-of-frame pulses
// (RULE_11) slave clears on sampled rollover pulse
// (RULE_12) header carries latched run start time
// (RULE_13) record number exceeds 130,000 records
// (RULE_14) event count holds at least 64K
// (RULE_15) count threshold pixels, bad-column, window discards
// (RULE_16) pulse-height discards span all CCD pixels
// (RULE_17) grade discard count, optional in telemetry
// (RULE_18) faint entry: ccd,row,col,3 ph,overclock,bias
// (RULE_19) graded entry: ccd,row,col,centre ph,grade
// (RULE_20) graded mode reuses faint header layout
// (RULE_21) row identifier kept for event timing
`timescale 1ns/1ps
module sts_timestamp (
  input wire logic mclk, // system clock, 50 MHz
  input wire logic resetn, // power-up reset, active low
  input wire logic frame_pulse, // science frame sync pin
  input wire logic link_ready, // interface unit accepts serial bits (pin)
  input wire logic run_start, // science run begins, one-cycle pulse
  input wire logic rec_end, // close record, emit header, pulse
  input wire logic grade_sel, // grade selection active
  input wire logic mode_graded, // 1 graded entries, 0 faint entries
  input wire logic evt_valid, // event offered
  input wire logic [sts_pkg::CCD_W-1:0] evt_ccd, // ccd identifier
  input wire logic [sts_pkg::ROW_W-1:0] evt_row, // summed row
  input wire logic [sts_pkg::COL_W-1:0] evt_col, // summed column
  input wire logic [sts_pkg::PH_W-1:0] evt_ph0, // left pulse height
  input wire logic [sts_pkg::PH_W-1:0] evt_ph1, // centre pulse height
  input wire logic [sts_pkg::PH_W-1:0] evt_ph2, // right pulse height
  input wire logic [sts_pkg::OVC_W-1:0] evt_ovc, // overclock level
  input wire logic [sts_pkg::BIAS_W-1:0] evt_bias, // spatial bias offset
  input wire logic [sts_pkg::GRD_W-1:0] evt_grade, // grade code
  input wire logic pix_above, // pixel over threshold, pulse
  input wire logic disc_badcol, // bad-column discard, pulse
  input wire logic disc_ph, // pulse-height discard, pulse
  input wire logic disc_grade, // grade discard, pulse
  input wire logic disc_window, // window discard, pulse
  output logic evt_ready, // event slot free
  output logic sdo, // serial science data, msb first
  output logic sdo_valid, // sdo carries a bit
  output logic slave_clear, // rollover broadcast pulse
  output logic bof, // beginning of ccd frame pulse
  output logic [sts_pkg::TS_W-1:0] ts_now, // master timestamp
  output logic [sts_pkg::TS_W-1:0] run_ts // latched run start time
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fp1;
    logic fp2;
    logic fp3;
    logic lr1;
    logic lr2;
    logic [sts_pkg::TICK_W-1:0] div;
    logic [sts_pkg::TS_W-1:0] ts;
    logic roll;
    logic [sts_pkg::TS_W-1:0] sl_ts;
    logic [sts_pkg::FRM_W-1:0] frm;
    logic bof;
    logic [sts_pkg::TS_W-1:0] run_ts;
    logic [sts_pkg::REC_W-1:0] rec;
    logic [sts_pkg::EVC_W-1:0] evc;
    logic [sts_pkg::PIX_W-1:0] pix;
    logic [sts_pkg::DSC_W-1:0] bad;
    logic [sts_pkg::PIX_W-1:0] phd;
    logic [sts_pkg::DSC_W-1:0] grd;
    logic [sts_pkg::DSC_W-1:0] win;
    logic stamp_pend;
    logic [sts_pkg::TS_W-1:0] stamp;
    logic hdr_pend;
    logic ev_full;
    logic ev_graded;
    logic [sts_pkg::CCD_W-1:0] ev_ccd;
    logic [sts_pkg::ROW_W-1:0] ev_row;
    logic [sts_pkg::COL_W-1:0] ev_col;
    logic [sts_pkg::PH_W-1:0] ev_ph0;
    logic [sts_pkg::PH_W-1:0] ev_ph1;
    logic [sts_pkg::PH_W-1:0] ev_ph2;
    logic [sts_pkg::OVC_W-1:0] ev_ovc;
    logic [sts_pkg::BIAS_W-1:0] ev_bias;
    logic [sts_pkg::GRD_W-1:0] ev_grade;
    sts_pkg::sts_seq_e st;
    logic [sts_pkg::IDX_W-1:0] idx;
    logic [sts_pkg::WORD_W-1:0] sh;
    logic [sts_pkg::BIT_W-1:0] bits;
    logic sdo;
    logic sdo_v;
    logic evt_rdy;
  } sts_st_s;

  sts_st_s q, n;
  logic tick_now;
  logic fp_edge;
  logic push_v;
  logic [sts_pkg::WORD_W-1:0] push_d;
  logic fifo_rdy;
  logic fifo_ov;
  logic [sts_pkg::WORD_W-1:0] fifo_od;
  logic fifo_take;
  logic hdr_done;
  logic [sts_pkg::IDX_W-1:0] hdr_last;
  logic [sts_pkg::IDX_W-1:0] evt_last;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // counter step; an increment in the clearing cycle is kept
  function automatic logic [sts_pkg::CNT_W-1:0] cnt_nx(
    input logic [sts_pkg::CNT_W-1:0] v,
    input logic inc,
    input logic clr
  );
    logic [sts_pkg::CNT_W-1:0] one;
    one = {{(sts_pkg::CNT_W-1){1'b0}}, inc};
    return clr ? one : sts_pkg::CNT_W'(v + one);
  endfunction : cnt_nx

  function automatic logic [sts_pkg::WORD_W-1:0] evt_word(
    input sts_st_s s
  );
    logic [sts_pkg::WORD_W-1:0] w;
    w = '0;
    case (s.idx)
      3'h0: w = {s.ev_ccd, s.ev_row, s.ev_col, 8'h00};
      3'h1: w = s.ev_graded ? {s.ev_ph1, s.ev_grade, 12'h000}
                            : {s.ev_ph0, s.ev_ph1, 8'h00};
      3'h2: w = {s.ev_ph2, s.ev_ovc, s.ev_bias};
      default: w = '0;
    endcase
    return w;
  endfunction : evt_word

  // same layout for faint and graded records
  function automatic logic [sts_pkg::WORD_W-1:0] hdr_word(
    input sts_st_s s
  );
    logic [sts_pkg::WORD_W-1:0] w;
    w = '0;
    case (s.idx)
      3'h0: w = s.run_ts;
      3'h1: w = sts_pkg::WORD_W'(s.rec);
      3'h2: w = sts_pkg::WORD_W'(s.evc);
      3'h3: w = sts_pkg::WORD_W'(s.pix);
      3'h4: w = sts_pkg::WORD_W'(s.bad);
      3'h5: w = sts_pkg::WORD_W'(s.phd);
      3'h6: w = sts_pkg::WORD_W'(s.win);
      3'h7: w = sts_pkg::WORD_W'(s.grd);
      default: w = '0;
    endcase
    return w;
  endfunction : hdr_word

  // ----------------------------------------------------------------
  // output fifo
  // ----------------------------------------------------------------
  sts_fifo #(
    .W(sts_pkg::WORD_W),
    .D(sts_pkg::FIFO_D)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(push_v),
    .in_ready(fifo_rdy),
    .in_data(push_d),
    .out_valid(fifo_ov),
    .out_ready(fifo_take),
    .out_data(fifo_od)
  );

  assign fifo_take = (q.bits == '0);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    push_v = 1'b0;
    push_d = '0;
    hdr_done = 1'b0;
    hdr_last = grade_sel ? sts_pkg::HDR_LAST_G : sts_pkg::HDR_LAST_N; // see RULE_17
    evt_last = q.ev_graded ? sts_pkg::GRD_LAST : sts_pkg::FNT_LAST;
    n.fp1 = frame_pulse;
    n.fp2 = q.fp1;
    n.fp3 = q.fp2;
    n.lr1 = link_ready;
    n.lr2 = q.lr1;
    fp_edge = q.fp2 && !q.fp3; // see RULE_06

    // pixel-rate tick, one per 500 system clocks
    tick_now = (q.div == sts_pkg::TICK_LAST); // see RULE_04
    n.div = tick_now ? sts_pkg::TICK_RST : sts_pkg::TICK_W'(q.div + 1'b1);

    // master counter: only power-up reset clears it
    n.roll = 1'b0;
    if (tick_now) begin
      if (q.ts == sts_pkg::TS_MAX) begin
        n.ts = sts_pkg::TS_RST; // see RULE_02
        n.roll = 1'b1; // see RULE_09
      end else begin
        n.ts = sts_pkg::TS_W'(q.ts + 1'b1); // see RULE_08
      end
    end

    // slave counter and frame timing
    n.bof = 1'b0;
    if (q.roll) begin
      n.sl_ts = sts_pkg::TS_RST; // see RULE_11
      n.frm = '0;
    end else if (tick_now) begin
      n.sl_ts = sts_pkg::TS_W'(q.sl_ts + 1'b1);
      n.frm = (q.frm == sts_pkg::FRAME_TICKS - 1'b1) ? '0
            : sts_pkg::FRM_W'(q.frm + 1'b1);
      n.bof = (q.frm == '0); // see RULE_10
    end

    // event capture
    if (evt_valid && q.evt_rdy) begin
      n.ev_full = 1'b1;
      n.ev_graded = mode_graded;
      n.ev_ccd = evt_ccd;
      n.ev_row = evt_row; // see RULE_21
      n.ev_col = evt_col;
      n.ev_ph0 = evt_ph0;
      n.ev_ph1 = evt_ph1;
      n.ev_ph2 = evt_ph2;
      n.ev_ovc = evt_ovc;
      n.ev_bias = evt_bias;
      n.ev_grade = evt_grade;
    end
    if (rec_end) begin
      n.hdr_pend = 1'b1;
    end

    // word sequencer; a pending stamp goes ahead of any other word
    if (q.stamp_pend) begin
      push_v = 1'b1;
      push_d = q.stamp; // see RULE_01
      if (fifo_rdy) begin
        n.stamp_pend = 1'b0;
      end
    end else begin
      case (q.st)
        sts_pkg::SEQ_IDLE: begin
          n.idx = '0;
          if (q.hdr_pend) begin
            n.st = sts_pkg::SEQ_HDR;
          end else if (q.ev_full) begin
            n.st = sts_pkg::SEQ_EVT;
          end
        end
        sts_pkg::SEQ_EVT: begin
          push_v = 1'b1;
          push_d = evt_word(q); // see RULE_18 RULE_19
          if (fifo_rdy) begin
            n.idx = sts_pkg::IDX_W'(q.idx + 1'b1);
            if (q.idx == evt_last) begin
              n.ev_full = 1'b0;
              n.st = sts_pkg::SEQ_IDLE;
            end
          end
        end
        sts_pkg::SEQ_HDR: begin
          push_v = 1'b1;
          push_d = hdr_word(q); // see RULE_12 RULE_20
          if (fifo_rdy) begin
            n.idx = sts_pkg::IDX_W'(q.idx + 1'b1);
            if (q.idx == hdr_last) begin
              hdr_done = 1'b1;
              n.hdr_pend = rec_end;
              n.st = sts_pkg::SEQ_IDLE;
            end
          end
        end
        default: begin
          n.st = sts_pkg::SEQ_IDLE;
        end
      endcase
    end
    // a new frame edge beats the clear of the previous stamp
    if (fp_edge) begin
      n.stamp = q.ts; // see RULE_01
      n.stamp_pend = 1'b1;
    end

    // record header counters, cleared as the header completes; the record number steps instead
    n.evc = sts_pkg::EVC_W'(cnt_nx(sts_pkg::CNT_W'(q.evc), evt_valid && q.evt_rdy,
                                   hdr_done)); // see RULE_14
    n.pix = sts_pkg::PIX_W'(cnt_nx(sts_pkg::CNT_W'(q.pix), pix_above, hdr_done)); // see RULE_15
    n.bad = sts_pkg::DSC_W'(cnt_nx(sts_pkg::CNT_W'(q.bad), disc_badcol, hdr_done)); // see RULE_15
    n.win = sts_pkg::DSC_W'(cnt_nx(sts_pkg::CNT_W'(q.win), disc_window, hdr_done)); // see RULE_15
    n.phd = sts_pkg::PIX_W'(cnt_nx(sts_pkg::CNT_W'(q.phd), disc_ph, hdr_done)); // see RULE_16
    n.grd = sts_pkg::DSC_W'(cnt_nx(sts_pkg::CNT_W'(q.grd), disc_grade, hdr_done)); // see RULE_17
    if (hdr_done) begin
      n.rec = sts_pkg::REC_W'(q.rec + 1'b1); // see RULE_05 RULE_13
    end
    // run start samples the same master counter
    if (run_start) begin
      n.run_ts = q.ts; // see RULE_03
      n.rec = '0; // see RULE_05
    end
    n.evt_rdy = !n.ev_full;

    // serialiser, stalls while the interface unit is not ready
    n.sdo_v = 1'b0;
    if (q.bits == '0) begin
      if (fifo_ov) begin
        n.sh = fifo_od;
        n.bits = sts_pkg::WORD_BITS;
      end
    end else if (q.lr2) begin
      n.sdo = q.sh[sts_pkg::WORD_W-1];
      n.sdo_v = 1'b1;
      n.sh = {q.sh[sts_pkg::WORD_W-2:0], 1'b0};
      n.bits = sts_pkg::BIT_W'(q.bits - 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0; // see RULE_07
    end else begin
      q <= n;
    end
  end

  assign evt_ready = q.evt_rdy;
  assign sdo = q.sdo;
  assign sdo_valid = q.sdo_v;
  assign slave_clear = q.roll;
  assign bof = q.bof;
  assign ts_now = q.ts;
  assign run_ts = q.run_ts;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence frame_seen;
    q.fp2 && !q.fp3;
  endsequence
  sequence stamp_sent;
    q.stamp_pend && fifo_rdy;
  endsequence
  sequence wrap_tick;
    tick_now && q.ts == sts_pkg::TS_MAX;
  endsequence

  stamp_sample_a: assert property (frame_seen |=> q.stamp_pend && q.stamp == $past(q.ts)) // see RULE_01
    else $error("frame stamp not sampled");
  stamp_first_a: assert property (stamp_sent |-> push_v && push_d == q.stamp) // see RULE_01
    else $error("stamp not first word pushed");
  ts_step_a: assert property (tick_now && q.ts != sts_pkg::TS_MAX |=> q.ts == $past(q.ts) + 1) // see RULE_08
    else $error("master counter did not step");
  ts_hold_a: assert property (!tick_now |=> $stable(q.ts)) // see RULE_07
    else $error("master counter moved off tick");
  tick_gap_a: assert property (tick_now |=> (!tick_now) [*8]) // see RULE_04
    else $error("pixel tick too frequent");
  roll_pulse_a: assert property (wrap_tick |=> q.roll && q.ts == '0 ##1 !q.roll) // see RULE_09
    else $error("rollover pulse wrong");
  slave_clear_a: assert property (q.roll |=> q.sl_ts == '0 && q.frm == '0) // see RULE_11
    else $error("slave counter not cleared");
  run_latch_a: assert property (run_start |=> q.run_ts == $past(q.ts) && q.rec == '0) // see RULE_03
    else $error("run start not latched");
  rec_step_a: assert property (hdr_done && !run_start |=> q.rec == $past(q.rec) + 1) // see RULE_05
    else $error("record number not advanced");
  bof_frame_a: assert property (q.bof |-> $past(q.frm) == '0 && $past(tick_now)) // see RULE_10
    else $error("frame start pulse misplaced");

endmodule : sts_timestamp

// File: verification/sts_sif_model.sv
`timescale 1ns/1ps
module sts_sif_model (
  input wire logic mclk, // system clock
  input wire logic sdo, // serial science data from block
  input wire logic sdo_valid, // sdo carries a bit
  input wire logic stall, // bench asks the link to hold off
  output logic frame_pulse, // science frame sync to block
  output logic link_ready // link accepts serial bits
);
  logic [31:0] shift_q;
  int nbits;
  logic [31:0] words[$];

  initial begin
    frame_pulse = 1'b0;
    link_ready = 1'b0;
    shift_q = 32'h0000_0000;
    nbits = 0;
  end

  // ----------------------------------------------------------------
  // receiver: msb arrives first, so shift in at the bottom
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    link_ready <= #1 !stall;
    if (sdo_valid === 1'b1) begin
      shift_q = {shift_q[30:0], sdo};
      nbits++;
      if (nbits == 32) begin
        words.push_back(shift_q);
        nbits = 0;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame sync: held four cycles so the synchroniser cannot miss it
  // ----------------------------------------------------------------
  task automatic frame_sync();
    @(posedge mclk);
    #1 frame_pulse = 1'b1;
    repeat (4) @(posedge mclk);
    #1 frame_pulse = 1'b0;
  endtask : frame_sync
endmodule : sts_sif_model

// File: verification/test_sts_timestamp.sv
`timescale 1ns/1ps
module test_sts_timestamp;
  logic mclk, resetn, run_start, rec_end, grade_sel, mode_graded, evt_valid;
  logic [3:0] evt_ccd;
  logic [9:0] evt_row, evt_col;
  logic [11:0] evt_ph0, evt_ph1, evt_ph2, evt_bias;
  logic [7:0] evt_ovc, evt_grade;
  logic pix_above, disc_badcol, disc_ph, disc_grade, disc_window, stall;
  logic frame_pulse, link_ready, evt_ready, sdo, sdo_valid, slave_clear, bof;
  logic [31:0] ts_now, run_ts, run_exp;
  logic [31:0] exp_q[$];
  int errors = 0;
  int checked = 0;
  int cyc = 0;

  sts_timestamp u_dut (.mclk(mclk), .resetn(resetn), .frame_pulse(frame_pulse),
    .link_ready(link_ready), .run_start(run_start), .rec_end(rec_end),
    .grade_sel(grade_sel), .mode_graded(mode_graded), .evt_valid(evt_valid),
    .evt_ccd(evt_ccd), .evt_row(evt_row), .evt_col(evt_col), .evt_ph0(evt_ph0),
    .evt_ph1(evt_ph1), .evt_ph2(evt_ph2), .evt_ovc(evt_ovc), .evt_bias(evt_bias),
    .evt_grade(evt_grade), .pix_above(pix_above), .disc_badcol(disc_badcol),
    .disc_ph(disc_ph), .disc_grade(disc_grade), .disc_window(disc_window),
    .evt_ready(evt_ready), .sdo(sdo), .sdo_valid(sdo_valid),
    .slave_clear(slave_clear), .bof(bof), .ts_now(ts_now), .run_ts(run_ts));

  sts_sif_model u_sif (.mclk(mclk), .sdo(sdo), .sdo_valid(sdo_valid), .stall(stall),
    .frame_pulse(frame_pulse), .link_ready(link_ready));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = !mclk;
  end

  always @(posedge mclk) if (resetn) cyc <= cyc + 1;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // expected stamp from our own edge count; callers stay mid-tick
  function automatic logic [31:0] exp_ts();
    return 32'(cyc / sts_pkg::TICK_CYC);
  endfunction : exp_ts

  task automatic mid_tick();
    while (cyc % sts_pkg::TICK_CYC != 200) @(posedge mclk);
  endtask : mid_tick

  task automatic check_stream();
    int n;
    for (n = 0; n < 3000 && u_sif.words.size() < exp_q.size(); n++) @(posedge mclk);
    chk_word(32'(u_sif.words.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) if (i < u_sif.words.size()) chk_word(u_sif.words[i], exp_q[i]);
    exp_q.delete();
    u_sif.words.delete();
  endtask : check_stream

  task automatic send_evt(input logic graded, input logic [7:0] k, output logic acc);
    int n;
    @(posedge mclk);
    #1 evt_valid = 1'b1;
    mode_graded = graded;
    {evt_ccd, evt_row, evt_col} = {k[3:0], 10'h155 + 10'(k), 10'h2AA - 10'(k)};
    {evt_ph0, evt_ph1, evt_ph2} = {12'hA00 + 12'(k), 12'h5F0 + 12'(k), 12'h0C3 + 12'(k)};
    {evt_ovc, evt_bias, evt_grade} = {8'h7E, 12'h9A5, 8'h40 + k};
    acc = 1'b0;
    for (n = 0; n < 40 && !acc; n++) begin
      @(posedge mclk);
      acc = (evt_ready === 1'b1);
    end
    #1 evt_valid = 1'b0;
    if (acc) begin
      exp_q.push_back({evt_ccd, evt_row, evt_col, 8'h00});
      if (graded) exp_q.push_back({evt_ph1, evt_grade, 12'h000});
      else begin
        exp_q.push_back({evt_ph0, evt_ph1, 8'h00});
        exp_q.push_back({evt_ph2, evt_ovc, evt_bias});
      end
    end
  endtask : send_evt

  task automatic pulse_rec_end();
    @(posedge mclk);
    #1 rec_end = 1'b1;
    @(posedge mclk);
    #1 rec_end = 1'b0;
  endtask : pulse_rec_end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_tick();
    int n;
    chk_word(ts_now, 32'h0000_0000);
    for (n = 0; n < 600 && ts_now !== 32'h0000_0001; n++) begin
      @(posedge mclk);
      #2;
    end
    chk_word(32'(cyc), 32'(sts_pkg::TICK_CYC));
    chk_word(32'(bof), 32'h0000_0001);
    chk_word(32'(slave_clear), 32'h0000_0000);
    for (n = 0; n < 600 && ts_now !== 32'h0000_0002; n++) begin
      @(posedge mclk);
      #2;
    end
    chk_word(32'(cyc), 32'(2 * sts_pkg::TICK_CYC));
    $display("test tick done");
  endtask : t_tick

  task automatic t_events();
    logic acc;
    send_evt(1'b0, 8'h01, acc);
    send_evt(1'b1, 8'h02, acc);
    send_evt(1'b1, 8'h03, acc);
    send_evt(1'b0, 8'h04, acc);
    check_stream();
    $display("test events done");
  endtask : t_events

  task automatic t_fill();
    logic acc;
    logic refused;
    refused = 1'b0;
    #1 stall = 1'b1;
    repeat (4) @(posedge mclk);
    for (int k = 0; k < 6 && !refused; k++) begin
      send_evt(1'(k), 8'(8'h10 + k), acc);
      refused = !acc;
    end
    chk_word(32'(refused), 32'h0000_0001);
    @(posedge mclk);
    #1 stall = 1'b0;
    check_stream();
    $display("test fill done");
  endtask : t_fill

  task automatic t_frame();
    mid_tick();
    exp_q.push_back(exp_ts());
    u_sif.frame_sync();
    check_stream();
    $display("test frame done");
  endtask : t_frame

  task automatic t_header();
    logic acc;
    mid_tick();
    #1 run_start = 1'b1;
    @(posedge mclk);
    run_exp = exp_ts();
    #1 run_start = 1'b0;
    repeat (2) @(posedge mclk);
    chk_word(run_ts, run_exp);
    #1 grade_sel = 1'b1;
    pulse_rec_end();
    repeat (300) @(posedge mclk);
    chk_word(u_sif.words[0], run_exp);
    chk_word(u_sif.words[1], 32'h0000_0000);
    chk_word(u_sif.words[2], 32'h0000_0009);
    u_sif.words.delete();
    send_evt(1'b0, 8'h21, acc);
    #1 {pix_above, disc_badcol, disc_ph, disc_grade, disc_window} = 5'h1F;
    @(posedge mclk);
    #1 {pix_above, disc_badcol, disc_ph, disc_grade, disc_window} = 5'h14;
    @(posedge mclk);
    #1 {pix_above, disc_badcol, disc_ph, disc_grade, disc_window} = 5'h10;
    @(posedge mclk);
    #1 {pix_above, disc_badcol, disc_ph, disc_grade, disc_window} = 5'h00;
    pulse_rec_end();
    exp_q.push_back(run_exp);
    exp_q = {exp_q, 32'h1, 32'h1, 32'h3, 32'h1, 32'h2, 32'h1, 32'h1};
    check_stream();
    #1 grade_sel = 1'b0;
    pulse_rec_end();
    exp_q = {run_exp, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    check_stream();
    $display("test header done");
  endtask : t_header

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    print_verdict();
  end

  initial begin
    {resetn, run_start, rec_end, grade_sel, mode_graded, evt_valid, stall} = 7'h00;
    {evt_ccd, evt_row, evt_col, evt_ph0, evt_ph1, evt_ph2} = 60'h0;
    {evt_ovc, evt_bias, evt_grade} = 28'h0;
    {pix_above, disc_badcol, disc_ph, disc_grade, disc_window} = 5'h00;
    repeat (4) @(posedge mclk);
    #1 resetn = 1'b1;
    t_tick();
    t_events();
    t_fill();
    t_frame();
    t_header();
    print_verdict();
  end
endmodule : test_sts_timestamp
